// >>> dhs_consts.svh
/*
 constants for the driver diagnostic and high-speed mode block.
 assumes inclusion by bare name from the short guard, the diagnostic top and the bench.
*/
`ifndef DHS_CONSTS_SVH
`define DHS_CONSTS_SVH
`define DHS_ADR_CTRL 8'h00
`define DHS_ADR_HVLIM 8'h04
`define DHS_ADR_PWMLIM 8'h08
`define DHS_ADR_STATUS 8'h0C
`define DHS_ADR_IRQ_ST 8'h10
`define DHS_ADR_IRQ_MASK 8'h14
`define DHS_ADR_STEP 8'h18
`define DHS_CTRL_FS 0
`define DHS_CTRL_CHM 1
`define DHS_CTRL_PWM 2
`define DHS_CTRL_EN 3
`define DHS_CTRL_TOFF_LO 4
`define DHS_CTRL_TOFF_HI 7
`define DHS_CTRL_RST 32'h0000_0000
`define DHS_PER_RST 20'hF_FFFF
`define DHS_ST_OTPW 0
`define DHS_ST_OT 1
`define DHS_ST_SA 2
`define DHS_ST_SB 3
`define DHS_ST_OLA 4
`define DHS_ST_OLB 5
`define DHS_ST_FS 6
`define DHS_ST_CHM 7
`define DHS_ST_PWM 8
`define DHS_NSTAT 9
`define DHS_NIRQ 6
`define DHS_RETRIES 2'h3
`define DHS_POS_45 8'h80
`define DHS_PIN_IDLE 6'h30
`endif

// >>> dhs_pkg.sv
/*
 types for the driver diagnostic and high-speed mode block.
 assumes nothing beyond a sv compiler.
*/
package dhs_pkg;
  typedef enum logic [1:0] {
    DHS_S_RUN = 2'b00,
    DHS_S_RETRY = 2'b01,
    DHS_S_OFF = 2'b10
  } dhs_short_t;
endpackage

// >>> dhs_short_if.sv
/*
 interface between the diagnostic top and the per-coil short guard.
 assumes one guard instance per coil on the same clock.
*/
`timescale 1ns/1ps
interface dhs_short_if;
  logic det;
  logic restart;
  logic bridge_off;
  logic flag;
  modport guard (input det, input restart, output bridge_off, output flag);
  modport top (output det, output restart, input bridge_off, input flag);
endinterface

// >>> dhs_short_guard.sv
/*
 per-coil short-to-ground guard with retry count and latched shutdown.
 assumes det is already synchronised and restart is a one-cycle pulse.
*/
`timescale 1ns/1ps
`include "dhs_consts.svh"
module dhs_short_guard (
  input wire logic clk,
  input wire logic nrst,
  dhs_short_if.guard s
);
  dhs_pkg::dhs_short_t state_r;
  logic [1:0] tries_r;
  logic det_d_r;
  wire det_rise = s.det & ~det_d_r;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      det_d_r <= 1'b0;
    end else begin
      det_d_r <= s.det;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r <= dhs_pkg::DHS_S_RUN;
      tries_r <= 2'h0;
    end else begin
      unique case (state_r)
        dhs_pkg::DHS_S_RUN: begin
          tries_r <= 2'h0;
          if (det_rise) begin
            state_r <= dhs_pkg::DHS_S_RETRY;
          end
        end
        dhs_pkg::DHS_S_RETRY: begin
          if (det_rise) begin
            if (tries_r == `DHS_RETRIES - 2'h1) begin
              state_r <= dhs_pkg::DHS_S_OFF;
            end else begin
              tries_r <= tries_r + 2'h1;
            end
          end
        end
        dhs_pkg::DHS_S_OFF: begin
          if (s.restart) begin
            state_r <= dhs_pkg::DHS_S_RUN;
          end
        end
        default: state_r <= dhs_pkg::DHS_S_RUN;
      endcase
      if (s.restart && state_r != dhs_pkg::DHS_S_OFF) begin
        state_r <= dhs_pkg::DHS_S_RUN;
      end
    end
  end

  assign s.bridge_off = (state_r == dhs_pkg::DHS_S_OFF);
  assign s.flag = (state_r == dhs_pkg::DHS_S_OFF);
endmodule

// >>> dhs_diag_top.sv
/*
 high-speed mode switching and driver diagnostic flags with wishbone registers.
 assumes classic wishbone master on clk; sensor pins are asynchronous.
*/
// The Wishbone slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "dhs_consts.svh"
module dhs_diag_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [19:0] measured_step_period,
  input wire logic standstill,
  input wire logic [7:0] mstep_pos,
  input wire logic [7:0] table_current_a,
  input wire logic [7:0] table_current_b,
  input wire logic [7:0] table_current_45,
  input wire logic temp_warn_pin,
  input wire logic temp_shut_pin,
  input wire logic short_a_pin,
  input wire logic short_b_pin,
  input wire logic reached_a_pin,
  input wire logic reached_b_pin,
  output logic fullstep_active,
  output logic [7:0] target_current_a,
  output logic [7:0] target_current_b,
  output logic chopper_select,
  output logic fast_decay_zero,
  output logic [4:0] off_time,
  output logic pwm_active,
  output logic stall_use_high_speed,
  output logic bridge_a_on,
  output logic bridge_b_on,
  output logic irq
);
  logic [31:0] ctrl_r;
  logic [19:0] high_velocity_limit_r;
  logic [19:0] pwm_velocity_limit_r;
  logic [`DHS_NIRQ-1:0] irq_st_r;
  logic [`DHS_NIRQ-1:0] irq_mask_r;
  logic [`DHS_NIRQ-1:0] ev;
  logic [`DHS_NIRQ-1:0] flags_d_r;
  logic [`DHS_NIRQ-1:0] w1c;
  logic [`DHS_NSTAT-1:0] driver_status_word;
  logic [5:0] s1_r;
  logic [5:0] s2_r;
  logic [5:0] s3_r;
  logic [5:0] clean_r;
  logic otpw_r;
  logic thermal_shutdown_flag_r;
  logic ola_r;
  logic olb_r;
  logic fs_r;
  logic en_d_r;
  logic restart;
  logic high_vel;
  logic chm_on;
  logic coil_a_short_flag;
  logic coil_b_short_flag;
  logic wb_req;
  logic [31:0] rd;
  dhs_short_if sa();
  dhs_short_if sb();

  // three-stage sampling; a change counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (!nrst) begin
      // start at the pins' idle levels so that no false edge follows reset
      s1_r <= `DHS_PIN_IDLE;
      s2_r <= `DHS_PIN_IDLE;
      s3_r <= `DHS_PIN_IDLE;
      clean_r <= `DHS_PIN_IDLE;
    end else begin
      s1_r <= {reached_b_pin, reached_a_pin, short_b_pin, short_a_pin,
               temp_shut_pin, temp_warn_pin};
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < 6; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          clean_r[i] <= s3_r[i];
        end
      end
    end
  end

  assign high_vel = (measured_step_period <= high_velocity_limit_r);
  assign chm_on = ctrl_r[`DHS_CTRL_CHM] & high_vel;

  // fullstep entry only at 45 degree point, leaves when speed drops
  always_ff @(posedge clk) begin
    if (!nrst) begin
      fs_r <= 1'b0;
    end else if (!(ctrl_r[`DHS_CTRL_FS] && high_vel)) begin
      fs_r <= 1'b0;
    end else if (mstep_pos == `DHS_POS_45) begin
      fs_r <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      target_current_a <= 8'h00;
      target_current_b <= 8'h00;
      chopper_select <= 1'b0;
      fast_decay_zero <= 1'b0;
      off_time <= 5'h00;
      pwm_active <= 1'b0;
    end else begin
      target_current_a <= fs_r ? table_current_45 : table_current_a;
      target_current_b <= fs_r ? table_current_45 : table_current_b;
      chopper_select <= chm_on;
      fast_decay_zero <= chm_on;
      off_time <= chm_on ? {ctrl_r[`DHS_CTRL_TOFF_HI:`DHS_CTRL_TOFF_LO], 1'b0}
                         : {1'b0, ctrl_r[`DHS_CTRL_TOFF_HI:`DHS_CTRL_TOFF_LO]};
      // host raises the enable only at standstill
      pwm_active <= ctrl_r[`DHS_CTRL_PWM] & ~high_vel
                    & (measured_step_period >= pwm_velocity_limit_r);
    end
  end

  assign fullstep_active = fs_r;
  assign stall_use_high_speed = fs_r;

  // thermal: shutdown latches until pre-warning clears
  always_ff @(posedge clk) begin
    if (!nrst) begin
      otpw_r <= 1'b0;
      thermal_shutdown_flag_r <= 1'b0;
    end else begin
      otpw_r <= clean_r[0];
      if (clean_r[1]) begin
        thermal_shutdown_flag_r <= 1'b1;
      end else if (!clean_r[0]) begin
        thermal_shutdown_flag_r <= 1'b0;
      end
    end
  end

  // restart pulse on driver enable rising edge after a disable
  always_ff @(posedge clk) begin
    if (!nrst) begin
      en_d_r <= 1'b0;
    end else begin
      en_d_r <= ctrl_r[`DHS_CTRL_EN];
    end
  end
  assign restart = ctrl_r[`DHS_CTRL_EN] & ~en_d_r;

  assign sa.det = clean_r[2];
  assign sa.restart = restart;
  assign sb.det = clean_r[3];
  assign sb.restart = restart;
  dhs_short_guard u_guard_a (.clk(clk), .nrst(nrst), .s(sa));
  dhs_short_guard u_guard_b (.clk(clk), .nrst(nrst), .s(sb));
  assign coil_a_short_flag = sa.flag;
  assign coil_b_short_flag = sb.flag;

  // open load: not judged at standstill, flags only
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ola_r <= 1'b0;
      olb_r <= 1'b0;
    end else if (!standstill) begin
      ola_r <= ~clean_r[4];
      olb_r <= ~clean_r[5];
    end
  end
  // host reads open load only at low or nominal speed

  // open-load flags feed no stage control
  assign bridge_a_on = ctrl_r[`DHS_CTRL_EN] & ~thermal_shutdown_flag_r & ~sa.bridge_off;
  assign bridge_b_on = ctrl_r[`DHS_CTRL_EN] & ~thermal_shutdown_flag_r & ~sb.bridge_off;

  always_comb begin
    driver_status_word = '0;
    driver_status_word[`DHS_ST_OTPW] = otpw_r;
    driver_status_word[`DHS_ST_OT] = thermal_shutdown_flag_r;
    driver_status_word[`DHS_ST_SA] = coil_a_short_flag;
    driver_status_word[`DHS_ST_SB] = coil_b_short_flag;
    driver_status_word[`DHS_ST_OLA] = ola_r;
    driver_status_word[`DHS_ST_OLB] = olb_r;
    driver_status_word[`DHS_ST_FS] = fs_r;
    driver_status_word[`DHS_ST_CHM] = chopper_select;
    driver_status_word[`DHS_ST_PWM] = pwm_active;
  end

  // interrupt events on rising flags, set wins over write-one clear
  always_ff @(posedge clk) begin
    if (!nrst) begin
      flags_d_r <= '0;
    end else begin
      flags_d_r <= driver_status_word[`DHS_NIRQ-1:0];
    end
  end
  assign ev = driver_status_word[`DHS_NIRQ-1:0] & ~flags_d_r;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign w1c = (wb_req && wb_we_i && wb_adr_i == `DHS_ADR_IRQ_ST && wb_sel_i[0])
               ? wb_dat_i[`DHS_NIRQ-1:0] : '0;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_st_r <= '0;
    end else begin
      irq_st_r <= (irq_st_r & ~w1c) | ev;
    end
  end
  assign irq = |(irq_st_r & irq_mask_r);

  // register writes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_r <= `DHS_CTRL_RST;
      high_velocity_limit_r <= '0;
      pwm_velocity_limit_r <= `DHS_PER_RST;
      irq_mask_r <= '0;
    end else if (wb_req && wb_we_i) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          unique case (wb_adr_i)
            `DHS_ADR_CTRL: ctrl_r[b*8+:8] <= wb_dat_i[b*8+:8];
            default: ;
          endcase
        end
      end
      if (wb_adr_i == `DHS_ADR_HVLIM) begin
        if (wb_sel_i[0]) high_velocity_limit_r[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) high_velocity_limit_r[15:8] <= wb_dat_i[15:8];
        if (wb_sel_i[2]) high_velocity_limit_r[19:16] <= wb_dat_i[19:16];
      end
      if (wb_adr_i == `DHS_ADR_PWMLIM) begin
        if (wb_sel_i[0]) pwm_velocity_limit_r[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) pwm_velocity_limit_r[15:8] <= wb_dat_i[15:8];
        if (wb_sel_i[2]) pwm_velocity_limit_r[19:16] <= wb_dat_i[19:16];
      end
      if (wb_adr_i == `DHS_ADR_IRQ_MASK && wb_sel_i[0]) begin
        irq_mask_r <= wb_dat_i[`DHS_NIRQ-1:0];
      end
    end
  end

  always_comb begin
    rd = 32'h0000_0000;
    unique case (wb_adr_i)
      `DHS_ADR_CTRL: rd = {24'h00_0000, ctrl_r[7:0]};
      `DHS_ADR_HVLIM: rd = {12'h000, high_velocity_limit_r};
      `DHS_ADR_PWMLIM: rd = {12'h000, pwm_velocity_limit_r};
      `DHS_ADR_STATUS: rd = {23'h00_0000, driver_status_word};
      `DHS_ADR_IRQ_ST: rd = {26'h000_0000, irq_st_r};
      `DHS_ADR_IRQ_MASK: rd = {26'h000_0000, irq_mask_r};
      `DHS_ADR_STEP: rd = {12'h000, measured_step_period};
      default: rd = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        wb_dat_o <= rd;
      end
    end
  end
endmodule

// >>> dhs_diag_checker.sv
/*
 concurrent checks on the ports of the diagnostic and high-speed mode block.
 assumes one clock clk and synchronous active-low nrst.
*/
`timescale 1ns/1ps
module dhs_diag_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [7:0] mstep_pos,
  input wire logic [7:0] table_current_45,
  input wire logic fullstep_active,
  input wire logic [7:0] target_current_a,
  input wire logic chopper_select,
  input wire logic fast_decay_zero,
  input wire logic [4:0] off_time,
  input wire logic pwm_active,
  input wire logic stall_use_high_speed
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  fs_entry_point_a: assert property ($rose(fullstep_active) |-> $past(mstep_pos) == 8'h80)
    else $error("fullstep entered away from the 45 degree point");
  fs_target_a: assert property (fullstep_active && $past(fullstep_active)
    && $stable(table_current_45) |-> target_current_a == table_current_45)
    else $error("fullstep target differs from the 45 degree table value");
  chop_pair_a: assert property (chopper_select == fast_decay_zero)
    else $error("chopper select and fast decay zero disagree");
  off_even_a: assert property (chopper_select |-> off_time[0] == 1'b0)
    else $error("off time not doubled under chopper switching");
  stall_det_a: assert property (stall_use_high_speed == fullstep_active)
    else $error("stall detector choice differs from fullstep state");
  pwm_low_vel_a: assert property (pwm_active |-> !fullstep_active && !chopper_select)
    else $error("voltage pwm active at high velocity");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered in one cycle");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge longer than one cycle");
  cov_fs: cover property ($rose(fullstep_active));
  cov_chop: cover property ($rose(chopper_select));
  cov_pwm: cover property ($rose(pwm_active));
endmodule
bind dhs_diag_top dhs_diag_checker i_chk (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .mstep_pos(mstep_pos),
  .table_current_45(table_current_45), .fullstep_active(fullstep_active),
  .target_current_a(target_current_a), .chopper_select(chopper_select),
  .fast_decay_zero(fast_decay_zero), .off_time(off_time), .pwm_active(pwm_active),
  .stall_use_high_speed(stall_use_high_speed));

// >>> dhs_host_model.sv
/*
 host model: classic wishbone master doing single register cycles.
 assumes the slave answers on its own time; a stuck wait sets hung.
*/
`timescale 1ns/1ps
module dhs_host_model (
  input wire logic clk,
  output logic wb_cyc_i,
  output logic wb_stb_i,
  output logic wb_we_i,
  output logic [7:0] wb_adr_i,
  output logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o
);
  logic hung = 1'b0;
  initial begin
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
  end
  // called right after a rising edge; request held until ack is sampled
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    if (n >= 40) hung = 1'b1;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask
endmodule

// >>> test_driver_diag_and_highspeed_mode.sv
/*
 self-checking bench for the diagnostic and high-speed mode block.
 assumes the host model as bus master and fixed table currents.
*/
`timescale 1ns/1ps
`include "dhs_consts.svh"
module test_driver_diag_and_highspeed_mode;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [19:0] measured_step_period = 20'hF_FFFF;
  logic standstill = 1'b1;
  logic [7:0] mstep_pos = 8'h40;
  logic [7:0] table_current_a = 8'h21, table_current_b = 8'h32, table_current_45 = 8'h5A;
  logic temp_warn_pin = 1'b0, temp_shut_pin = 1'b0, short_a_pin = 1'b0, short_b_pin = 1'b0;
  logic reached_a_pin = 1'b1, reached_b_pin = 1'b1;
  logic fullstep_active, chopper_select, fast_decay_zero, pwm_active, stall_use_high_speed;
  logic bridge_a_on, bridge_b_on, irq;
  logic [7:0] target_current_a, target_current_b;
  logic [4:0] off_time;
  int err_count = 0;
  int cmp_count = 0;
  always #12.5 clk = ~clk;
  dhs_diag_top i_dut (.clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .measured_step_period, .standstill, .mstep_pos,
    .table_current_a, .table_current_b, .table_current_45, .temp_warn_pin, .temp_shut_pin,
    .short_a_pin, .short_b_pin, .reached_a_pin, .reached_b_pin, .fullstep_active,
    .target_current_a, .target_current_b, .chopper_select, .fast_decay_zero, .off_time,
    .pwm_active, .stall_use_high_speed, .bridge_a_on, .bridge_b_on, .irq);
  dhs_host_model i_host (.clk, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o);
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    i_host.xfer(1'b1, a, d, x);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    i_host.xfer(1'b0, a, 32'h0, q);
    chk(nm, exp, q);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic short_pulse();
    short_a_pin <= 1'b1;
    idle(8);
    short_a_pin <= 1'b0;
    idle(8);
  endtask
  task automatic t_regs();
    rchk("ctrl", `DHS_ADR_CTRL, `DHS_CTRL_RST);
    rchk("pwm limit", `DHS_ADR_PWMLIM, {12'h000, `DHS_PER_RST});
    rchk("period", `DHS_ADR_STEP, 32'h000F_FFFF);
    wr(8'h1C, 32'hFFFF_FFFF);
    rchk("unmapped", 8'h1C, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_fullstep();
    standstill <= 1'b0;
    measured_step_period <= 20'h0_0064;
    wr(`DHS_ADR_CTRL, 32'h09);
    wr(`DHS_ADR_HVLIM, 32'h64);
    idle(4);
    chk("fullstep off point", 32'h0, fullstep_active);
    mstep_pos <= 8'h80;
    idle(4);
    chk("fullstep at point", 32'h1, fullstep_active);
    chk("stall switch", 32'h1, stall_use_high_speed);
    chk("target a", 32'h5A, target_current_a);
    chk("target b", 32'h5A, target_current_b);
    rchk("status fs", `DHS_ADR_STATUS, 32'h040);
    measured_step_period <= 20'h0_0065;
    idle(4);
    chk("fullstep left", 32'h0, fullstep_active);
    chk("target a back", 32'h21, target_current_a);
    $display("test fullstep done");
  endtask
  task automatic t_chop();
    wr(`DHS_ADR_CTRL, 32'h5A);
    measured_step_period <= 20'h0_0064;
    idle(4);
    chk("chopper select", 32'h1, chopper_select);
    chk("fast decay zero", 32'h1, fast_decay_zero);
    chk("off time double", 32'h0A, off_time);
    chk("no fullstep", 32'h0, fullstep_active);
    measured_step_period <= 20'h0_0065;
    idle(4);
    chk("chopper normal", 32'h0, chopper_select);
    chk("off time plain", 32'h05, off_time);
    $display("test chopper done");
  endtask
  task automatic t_pwm();
    standstill <= 1'b1;
    measured_step_period <= 20'hF_FFFF;
    wr(`DHS_ADR_PWMLIM, 32'hC8);
    wr(`DHS_ADR_CTRL, 32'h0C);
    standstill <= 1'b0;
    measured_step_period <= 20'h0_00C8;
    idle(4);
    chk("pwm at limit", 32'h1, pwm_active);
    measured_step_period <= 20'h0_00C7;
    idle(4);
    chk("pwm above speed", 32'h0, pwm_active);
    $display("test pwm done");
  endtask
  task automatic t_thermal();
    wr(`DHS_ADR_CTRL, 32'h08);
    wr(`DHS_ADR_IRQ_ST, 32'h3F);
    wr(`DHS_ADR_IRQ_MASK, 32'h00);
    temp_warn_pin <= 1'b1;
    temp_shut_pin <= 1'b1;
    idle(8);
    chk("bridge hot", 32'h0, bridge_a_on);
    rchk("status hot", `DHS_ADR_STATUS, 32'h003);
    chk("irq masked", 32'h0, irq);
    wr(`DHS_ADR_IRQ_MASK, 32'h3F);
    chk("irq raised", 32'h1, irq);
    temp_shut_pin <= 1'b0;
    idle(8);
    chk("bridge still off", 32'h0, bridge_b_on);
    temp_warn_pin <= 1'b0;
    idle(8);
    chk("bridge cooled", 32'h1, bridge_a_on);
    rchk("status cool", `DHS_ADR_STATUS, 32'h000);
    wr(`DHS_ADR_IRQ_ST, 32'h03);
    chk("irq cleared", 32'h0, irq);
    rchk("irq status", `DHS_ADR_IRQ_ST, 32'h0);
    $display("test thermal done");
  endtask
  task automatic t_short();
    // first detection, then three retries before the bridge goes off
    short_pulse();
    short_pulse();
    short_pulse();
    chk("bridge retry", 32'h1, bridge_a_on);
    short_pulse();
    chk("bridge a off", 32'h0, bridge_a_on);
    chk("bridge b on", 32'h1, bridge_b_on);
    idle(20);
    rchk("status short", `DHS_ADR_STATUS, 32'h004);
    wr(`DHS_ADR_CTRL, 32'h00);
    wr(`DHS_ADR_CTRL, 32'h08);
    chk("bridge restart", 32'h1, bridge_a_on);
    rchk("status restart", `DHS_ADR_STATUS, 32'h000);
    $display("test short done");
  endtask
  task automatic t_open();
    reached_a_pin <= 1'b0;
    idle(8);
    rchk("status open", `DHS_ADR_STATUS, 32'h010);
    chk("bridge open", 32'h1, bridge_a_on);
    chk("target open", 32'h21, target_current_a);
    standstill <= 1'b1;
    reached_a_pin <= 1'b1;
    idle(8);
    rchk("status stopped", `DHS_ADR_STATUS, 32'h010);
    standstill <= 1'b0;
    idle(8);
    rchk("status reached", `DHS_ADR_STATUS, 32'h000);
    $display("test open load done");
  endtask
  task automatic summarize();
    if (i_host.hung) err_count++;
    $display("counts: %0d compared, %0d unexpected", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #500000;
    err_count++;
    summarize();
  end
  initial begin
    idle(3);
    nrst <= 1'b1;
    idle(1);
    t_regs();
    t_fullstep();
    t_chop();
    t_pwm();
    t_thermal();
    t_short();
    t_open();
    summarize();
  end
endmodule
